// *** hdl/slpc_consts.vh ***
// constants for the sleep and power-management controller
`ifndef SLPC_CONSTS_VH
`define SLPC_CONSTS_VH

`define SLPC_ADDR_CORE_CTRL   12'h000
`define SLPC_ADDR_CLK_GATE    12'h004
`define SLPC_ADDR_STATUS      12'h008
`define SLPC_ADDR_WAKE_CFG    12'h00c

`define SLPC_CTRL_BOD_OFF     7
`define SLPC_CTRL_SLEEP_EN    5
`define SLPC_CTRL_MODE_HI     4
`define SLPC_CTRL_MODE_LO     3
`define SLPC_CTRL_BOD_UNLOCK  2

`define SLPC_MODE_IDLE        2'h0
`define SLPC_MODE_NOISE       2'h1
`define SLPC_MODE_PDOWN       2'h2
`define SLPC_MODE_RSVD        2'h3

`define SLPC_GATE_TIMER_ONE   3
`define SLPC_GATE_TIMER_ZERO  2
`define SLPC_GATE_SERIAL      1
`define SLPC_GATE_CONVERTER   0

`define SLPC_WAKE_HOLD_CYC    4
`define SLPC_UNLOCK_WIN_CYC   4
`define SLPC_BROWNOUT_OFF_REQUEST_DELAY_CYC   3
`define SLPC_BROWNOUT_OFF_REQUEST_LIFE_CYC    3
`define SLPC_OSC_START_CYC    16
`define SLPC_RESET_START_CYC  64

`endif

// *** hdl/slpc_down_counter.v ***
// loadable down counter with done flag
`timescale 1ns/1ps
module slpc_down_counter
#(
   parameter W = 8
)
(
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   input  wire         load_i,
   input  wire [W-1:0] value_i,
   output wire         done_o
);
   reg [W-1:0] cnt_ff;
   always @(posedge clk_i)
   begin
      if (rst_i)
         cnt_ff <= {W{1'b0}};
      else if (ce_i)
      begin
         if (load_i)
            cnt_ff <= value_i;
         else if (cnt_ff != {W{1'b0}})
            cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
   end
   assign done_o = (cnt_ff == {W{1'b0}});
endmodule

// *** hdl/slpc_top.v ***
// sleep mode and power controller with apb registers
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "slpc_consts.vh"
module slpc_top
#(
   parameter OSC_START_CYC   = `SLPC_OSC_START_CYC,
   parameter RESET_START_CYC = `SLPC_RESET_START_CYC
)
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire        halt_instr_i,
   input  wire        sleep_reset_i,
   input  wire        irq_ext_line_i,
   input  wire        irq_pin_change_i,
   input  wire        irq_mem_ready_i,
   input  wire        irq_start_cond_i,
   input  wire        irq_converter_i,
   input  wire        irq_timer_i,
   input  wire        irq_other_io_i,
   input  wire        irq_watchdog_i,
   input  wire        converter_enabled_i,
   output wire        core_clock_en_o,
   output wire        program_memory_clock_en_o,
   output wire        peripheral_io_clock_en_o,
   output wire        converter_clock_en_o,
   output wire        pll_fast_clock_en_o,
   output wire        main_osc_en_o,
   output wire        brownout_detector_en_o,
   output wire        core_hold_o,
   output wire        resume_irq_o,
   output wire        resume_reset_o,
   output wire        conversion_start_o,
   output wire [3:0]  module_clock_gate_o,
   output wire [3:0]  module_io_block_o
);
   localparam ST_RUN   = 3'h0;
   localparam ST_SLEEP = 3'h1;
   localparam ST_START = 3'h2;
   localparam ST_HOLD  = 3'h3;
   localparam ST_RST   = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // timing counts, cut on purpose to the width of the counters they load
   localparam [31:0] UNLOCK_WIN_FULL = `SLPC_UNLOCK_WIN_CYC;
   localparam [31:0] BROWNOUT_OFF_REQUEST_DELAY_FULL = `SLPC_BROWNOUT_OFF_REQUEST_DELAY_CYC;
   localparam [31:0] BROWNOUT_OFF_REQUEST_LIFE_FULL  = `SLPC_BROWNOUT_OFF_REQUEST_LIFE_CYC;
   localparam [31:0] HOLD_LOAD_FULL  = `SLPC_WAKE_HOLD_CYC - 1;
   localparam [2:0]  UNLOCK_WIN      = UNLOCK_WIN_FULL[2:0];
   localparam [2:0]  BROWNOUT_OFF_REQUEST_DELAY      = BROWNOUT_OFF_REQUEST_DELAY_FULL[2:0];
   localparam [2:0]  BROWNOUT_OFF_REQUEST_LIFE       = BROWNOUT_OFF_REQUEST_LIFE_FULL[2:0];
   // loaded one short, so the hold state lasts the full count
   localparam [15:0] HOLD_LOAD       = HOLD_LOAD_FULL[15:0];

   ////////////////////////////////////////////////////////////////////////////
   // registers
   reg        sleep_enable_ff;
   reg [1:0]  low_power_select_ff;
   reg        brownout_off_request_ff;
   reg        brownout_off_request_armed_ff;
   reg [2:0]  unlock_cnt_ff;
   reg [2:0]  brownout_off_request_cnt_ff;
   reg [3:0]  module_clock_gate_reg_ff;
   reg        ext_level_mode_ff;
   reg [2:0]  state_ff;
   reg [1:0]  mode_ff;
   reg        bod_off_ff;
   reg        bod_slept_ff;
   reg        wake_rst_ff;
   reg        resume_irq_ff;
   reg        resume_reset_ff;
   reg        conv_start_ff;
   reg [31:0] prdata_ff;

   wire apb_wr = psel_i & penable_i & pwrite_i & ce_i;
   wire apb_rd = psel_i & penable_i & ~pwrite_i & ce_i;
   wire hit_ctrl = (paddr_i == `SLPC_ADDR_CORE_CTRL);
   wire hit_gate = (paddr_i == `SLPC_ADDR_CLK_GATE);
   wire hit_stat = (paddr_i == `SLPC_ADDR_STATUS);
   wire hit_wcfg = (paddr_i == `SLPC_ADDR_WAKE_CFG);
   wire hit_any  = hit_ctrl | hit_gate | hit_stat | hit_wcfg;

   // zero wait states: every access ends in its first access cycle
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit_any;
   assign prdata_o  = prdata_ff;

   wire wr_ctrl = apb_wr & hit_ctrl;
   wire wr_brownout_off_request = pwdata_i[`SLPC_CTRL_BOD_OFF];
   wire wr_unl  = pwdata_i[`SLPC_CTRL_BOD_UNLOCK];
   // usable once the armed delay is over, until the life count runs out
   wire brownout_off_request_active = brownout_off_request_ff & ~brownout_off_request_armed_ff;

   ////////////////////////////////////////////////////////////////////////////
   // control register, timed brown-out-off sequence
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sleep_enable_ff         <= 1'b0;
         low_power_select_ff     <= `SLPC_MODE_IDLE;
         brownout_off_request_ff <= 1'b0;
         brownout_off_request_armed_ff           <= 1'b0;
         unlock_cnt_ff           <= 3'h0;
         brownout_off_request_cnt_ff             <= 3'h0;
         module_clock_gate_reg_ff <= 4'h0;
         ext_level_mode_ff       <= 1'b0;
      end
      else if (ce_i)
      begin
         if (unlock_cnt_ff != 3'h0)
            unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
         if (brownout_off_request_cnt_ff != 3'h0)
            brownout_off_request_cnt_ff <= brownout_off_request_cnt_ff - 3'h1;
         // armed: request set but not yet usable; then a short usable life
         if (brownout_off_request_armed_ff && brownout_off_request_cnt_ff == 3'h1)
         begin
            brownout_off_request_armed_ff <= 1'b0;
            brownout_off_request_cnt_ff   <= BROWNOUT_OFF_REQUEST_LIFE;
         end
         else if (brownout_off_request_ff && !brownout_off_request_armed_ff && brownout_off_request_cnt_ff == 3'h1)
            brownout_off_request_ff <= 1'b0;
         // a second step in the clearing cycle re-arms: the write wins
         if (wr_ctrl)
         begin
            sleep_enable_ff     <= pwdata_i[`SLPC_CTRL_SLEEP_EN];
            low_power_select_ff <= pwdata_i[`SLPC_CTRL_MODE_HI:`SLPC_CTRL_MODE_LO];
            if (wr_brownout_off_request && wr_unl)
               unlock_cnt_ff <= UNLOCK_WIN;
            else if (wr_brownout_off_request && !wr_unl && unlock_cnt_ff != 3'h0)
            begin
               brownout_off_request_ff <= 1'b1;
               brownout_off_request_armed_ff           <= 1'b1;
               brownout_off_request_cnt_ff             <= BROWNOUT_OFF_REQUEST_DELAY;
               unlock_cnt_ff           <= 3'h0;
            end
         end
         if (apb_wr && hit_gate)
            module_clock_gate_reg_ff <= pwdata_i[3:0];
         if (apb_wr && hit_wcfg)
            ext_level_mode_ff <= pwdata_i[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always @(posedge clk_i)
   begin
      if (rst_i)
         prdata_ff <= 32'h0;
      else if (ce_i)
      begin
         // captured in setup, so the word stands through the access phase
         if (psel_i && !penable_i && !pwrite_i)
         begin
            case (paddr_i)
               `SLPC_ADDR_CORE_CTRL:
                  prdata_ff <= {24'h0, brownout_off_request_active, 1'b0, sleep_enable_ff,
                                low_power_select_ff, unlock_cnt_ff != 3'h0, 2'h0};
               `SLPC_ADDR_CLK_GATE:
                  prdata_ff <= {28'h0, module_clock_gate_reg_ff};
               `SLPC_ADDR_STATUS:
                  prdata_ff <= {27'h0, bod_slept_ff, state_ff, 1'b0};
               `SLPC_ADDR_WAKE_CFG:
                  prdata_ff <= {31'h0, ext_level_mode_ff};
               default:
                  prdata_ff <= 32'h0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wake source filter per mode
   reg wake_irq;
   always @*
   begin
      wake_irq = 1'b0;
      case (mode_ff)
         `SLPC_MODE_IDLE:
            wake_irq = irq_ext_line_i | irq_pin_change_i | irq_mem_ready_i |
                       irq_start_cond_i | irq_converter_i | irq_timer_i |
                       irq_other_io_i | irq_watchdog_i;
         `SLPC_MODE_NOISE:
            wake_irq = irq_converter_i | irq_mem_ready_i | irq_pin_change_i |
                       (irq_ext_line_i & ext_level_mode_ff);
         `SLPC_MODE_PDOWN:
            wake_irq = irq_start_cond_i | irq_pin_change_i | irq_watchdog_i |
                       (irq_ext_line_i & ext_level_mode_ff);
         default:
            wake_irq = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep sequencer
   wire start_done;
   wire hold_done;
   reg  start_load;
   reg  hold_load;
   reg  [15:0] start_val;
   // reserved select code leaves the core running through the halt
   wire enter = halt_instr_i & sleep_enable_ff & (low_power_select_ff != `SLPC_MODE_RSVD);

   always @*
   begin
      start_load = 1'b0;
      hold_load  = 1'b0;
      // reset start delay after brown-out off, so detector settles
      start_val  = bod_off_ff ? RESET_START_CYC[15:0] : OSC_START_CYC[15:0];
      if (state_ff == ST_SLEEP && (wake_irq || sleep_reset_i))
         start_load = 1'b1;
      if (state_ff == ST_START && start_done && !wake_rst_ff)
         hold_load = 1'b1;
   end

   slpc_down_counter #(.W(16)) u_start
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .load_i  (start_load),
      .value_i (start_val),
      .done_o  (start_done)
   );

   slpc_down_counter #(.W(16)) u_hold
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .load_i  (hold_load),
      .value_i (HOLD_LOAD),
      .done_o  (hold_done)
   );

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff        <= ST_RUN;
         mode_ff         <= `SLPC_MODE_IDLE;
         bod_off_ff      <= 1'b0;
         bod_slept_ff    <= 1'b0;
         wake_rst_ff     <= 1'b0;
         resume_irq_ff   <= 1'b0;
         resume_reset_ff <= 1'b0;
         conv_start_ff   <= 1'b0;
      end
      else if (ce_i)
      begin
         resume_irq_ff   <= 1'b0;
         resume_reset_ff <= 1'b0;
         conv_start_ff   <= 1'b0;
         // the strobes above last one cycle unless a transition raises them
         case (state_ff)
            ST_RUN:
               if (enter)
               begin
                  state_ff <= ST_SLEEP;
                  mode_ff  <= low_power_select_ff;
                  // only power-down may drop the detector
                  bod_off_ff <= brownout_off_request_active &&
                                (low_power_select_ff == `SLPC_MODE_PDOWN);
                  bod_slept_ff <= brownout_off_request_active &&
                                  (low_power_select_ff == `SLPC_MODE_PDOWN);
                  conv_start_ff <= converter_enabled_i &&
                                   (low_power_select_ff != `SLPC_MODE_PDOWN);
               end
            ST_SLEEP:
               // detector back on at wake, so it settles during the start count
               if (sleep_reset_i)
               begin
                  state_ff    <= ST_START;
                  wake_rst_ff <= 1'b1;
                  bod_off_ff  <= 1'b0;
               end
               else if (wake_irq)
               begin
                  state_ff    <= ST_START;
                  wake_rst_ff <= 1'b0;
                  bod_off_ff  <= 1'b0;
               end
            ST_START:
               // reset wake skips the interrupt hold and restarts at the vector
               if (start_done && !start_load)
               begin
                  state_ff   <= wake_rst_ff ? ST_RST : ST_HOLD;
               end
            ST_HOLD:
               if (hold_done && !hold_load)
               begin
                  state_ff      <= ST_RUN;
                  resume_irq_ff <= 1'b1;
               end
            ST_RST:
            begin
               state_ff        <= ST_RUN;
               resume_reset_ff <= 1'b1;
            end
            default:
               state_ff <= ST_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock enables; no reset of core state here keeps memory intact
   wire asleep = (state_ff == ST_SLEEP) | (state_ff == ST_START);
   wire m_idle = asleep & (mode_ff == `SLPC_MODE_IDLE);
   wire m_nois = asleep & (mode_ff == `SLPC_MODE_NOISE);
   wire m_pdwn = asleep & (mode_ff == `SLPC_MODE_PDOWN);
   // enables are combinational: the oscillator reopens at wake, the rest when the start count ends, without a lag cycle

   assign core_clock_en_o           = ~asleep;
   assign program_memory_clock_en_o = ~asleep;
   assign peripheral_io_clock_en_o  = ~(m_nois | m_pdwn);
   assign converter_clock_en_o      = ~m_pdwn;
   assign pll_fast_clock_en_o       = ~(m_nois | m_pdwn);
   // oscillator restarts during the start-up count
   assign main_osc_en_o             = ~(m_pdwn & (state_ff == ST_SLEEP));
   assign brownout_detector_en_o    = ~bod_off_ff;
   assign core_hold_o               = (state_ff != ST_RUN);
   assign resume_irq_o              = resume_irq_ff;
   assign resume_reset_o            = resume_reset_ff;
   assign conversion_start_o        = conv_start_ff;
   // gating moot in power-down: those clocks are already stopped (noise mode keeps the converter clock running)
   assign module_clock_gate_o = module_clock_gate_reg_ff;
   assign module_io_block_o   = module_clock_gate_reg_ff;
endmodule

// *** test/slpc_core_model.sv ***
// core-side model: issues halt and holds the external wake level
`timescale 1ns/1ps
module slpc_core_model
(
   input  wire clk_i,
   input  wire rst_i,
   input  wire halt_req_i,
   input  wire ext_req_i,
   input  wire resume_i,
   output reg  halt_instr_o = 1'b0,
   output reg  irq_ext_line_o = 1'b0
);
   always @(posedge clk_i)
   begin
      halt_instr_o <= halt_req_i & ~rst_i;
      // level kept until the core resumes, or the wake is lost
      if (rst_i | resume_i)
         irq_ext_line_o <= 1'b0;
      else if (ext_req_i)
         irq_ext_line_o <= 1'b1;
   end
endmodule

// *** test/slpc_top_chk.sv ***
// port assertions for the sleep controller
`timescale 1ns/1ps
module slpc_top_chk
#(
   parameter OSC_START_CYC   = 16,
   parameter RESET_START_CYC = 64
)
(
   input wire       clk_i,
   input wire       rst_i,
   input wire       halt_instr_i,
   input wire       converter_enabled_i,
   input wire       core_clock_en_o,
   input wire       program_memory_clock_en_o,
   input wire       peripheral_io_clock_en_o,
   input wire       converter_clock_en_o,
   input wire       pll_fast_clock_en_o,
   input wire       main_osc_en_o,
   input wire       brownout_detector_en_o,
   input wire       core_hold_o,
   input wire       resume_irq_o,
   input wire       resume_reset_o,
   input wire       conversion_start_o,
   input wire [3:0] module_clock_gate_o,
   input wire [3:0] module_io_block_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_halt_stops_core: assert property (
      $fell(core_clock_en_o) |-> $past(halt_instr_i)) else $error("core stopped without halt");
   a_flash_with_core: assert property (
      program_memory_clock_en_o == core_clock_en_o) else $error("program clock split");
   a_idle_keeps_io: assert property (
      peripheral_io_clock_en_o |-> converter_clock_en_o && pll_fast_clock_en_o && main_osc_en_o)
      else $error("idle clock set wrong");
   a_noise_clock_set: assert property (
      !peripheral_io_clock_en_o && converter_clock_en_o |->
      main_osc_en_o && !pll_fast_clock_en_o && !core_clock_en_o)
      else $error("noise clock set wrong");
   a_pdown_all_off: assert property (
      !main_osc_en_o |-> !(core_clock_en_o | peripheral_io_clock_en_o | converter_clock_en_o
      | pll_fast_clock_en_o)) else $error("clock left running");
   a_hold_before_run: assert property (
      resume_irq_o |-> $past(core_hold_o, 5) && $past(core_hold_o)) else $error("hold too short");
   a_resume_one_kind: assert property (
      resume_irq_o |-> !resume_reset_o ##1 !resume_irq_o) else $error("resume pulse wrong");
   a_gate_blocks_io: assert property (
      (module_clock_gate_o & ~module_io_block_o) == 4'h0) else $error("gated io open");
   a_bod_only_pdown: assert property (
      !brownout_detector_en_o |-> !main_osc_en_o) else $error("detector off outside pdown");
   a_conv_at_entry: assert property (
      conversion_start_o |-> converter_enabled_i && main_osc_en_o && !core_clock_en_o)
      else $error("conversion start misplaced");
endmodule
bind slpc_top slpc_top_chk #(.OSC_START_CYC(OSC_START_CYC), .RESET_START_CYC(RESET_START_CYC))
   slpc_top_chk_i (.clk_i(clk_i), .rst_i(rst_i), .halt_instr_i(halt_instr_i),
   .converter_enabled_i(converter_enabled_i), .core_clock_en_o(core_clock_en_o),
   .program_memory_clock_en_o(program_memory_clock_en_o),
   .peripheral_io_clock_en_o(peripheral_io_clock_en_o),
   .converter_clock_en_o(converter_clock_en_o), .pll_fast_clock_en_o(pll_fast_clock_en_o),
   .main_osc_en_o(main_osc_en_o), .brownout_detector_en_o(brownout_detector_en_o),
   .core_hold_o(core_hold_o), .resume_irq_o(resume_irq_o), .resume_reset_o(resume_reset_o),
   .conversion_start_o(conversion_start_o), .module_clock_gate_o(module_clock_gate_o),
   .module_io_block_o(module_io_block_o));

// *** test/slpc_top_tb.sv ***
// self-checking bench for the sleep controller
`timescale 1ns/1ps
module slpc_top_tb;
   localparam OSC = 4;
   localparam RST = 8;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         psel_i = 1'b0;
   reg         penable_i = 1'b0;
   reg         pwrite_i = 1'b0;
   reg  [11:0] paddr_i = 12'h000;
   reg  [31:0] pwdata_i = 32'h0;
   reg         halt_req = 1'b0;
   reg         ext_req = 1'b0;
   reg         sleep_reset_i = 1'b0;
   reg         conv_en = 1'b0;
   reg  [6:0]  irq_v = 7'h00;
   wire [31:0] prdata_o;
   wire        pready_o, pslverr_o, halt_i, ext_i, core_hold_o, resume_irq_o;
   wire        c_en, p_en, io_en, a_en, k_en, osc_en, bod_en, resume_reset_o, conv_o;
   wire [3:0]  gate_o, block_o;
   wire [5:0]  en_v = {c_en, p_en, io_en, a_en, k_en, osc_en};
   integer     failures = 0;
   integer     check_count = 0;
   integer     n, m;
   reg  [31:0] rdata;
   reg         rerr, rr, cs;
   always #12.5 clk_i = ~clk_i;
   slpc_top #(.OSC_START_CYC(OSC), .RESET_START_CYC(RST)) slpc_top_i (.clk_i(clk_i),
      .rst_i(rst_i), .ce_i(1'b1), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .halt_instr_i(halt_i), .sleep_reset_i(sleep_reset_i),
      .irq_ext_line_i(ext_i), .irq_pin_change_i(irq_v[0]), .irq_mem_ready_i(irq_v[1]),
      .irq_start_cond_i(irq_v[2]), .irq_converter_i(irq_v[3]), .irq_timer_i(irq_v[4]),
      .irq_other_io_i(irq_v[5]), .irq_watchdog_i(irq_v[6]), .converter_enabled_i(conv_en),
      .core_clock_en_o(c_en), .program_memory_clock_en_o(p_en),
      .peripheral_io_clock_en_o(io_en), .converter_clock_en_o(a_en),
      .pll_fast_clock_en_o(k_en), .main_osc_en_o(osc_en), .brownout_detector_en_o(bod_en),
      .core_hold_o(core_hold_o), .resume_irq_o(resume_irq_o), .resume_reset_o(resume_reset_o),
      .conversion_start_o(conv_o), .module_clock_gate_o(gate_o), .module_io_block_o(block_o));
   slpc_core_model slpc_core_model_i (.clk_i(clk_i), .rst_i(rst_i), .halt_req_i(halt_req),
      .ext_req_i(ext_req), .resume_i(resume_irq_o | resume_reset_o), .halt_instr_o(halt_i),
      .irq_ext_line_o(ext_i));
   ////////////////////////////////////////////////////////////////////////////
   task check(input [95:0] nm, input [31:0] e, input [31:0] g);
   begin
      check_count = check_count + 1;
      if (g !== e)
      begin
         failures = failures + 1;
         $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   // one idle edge after each transfer keeps the next setup off this step
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1)
         @(posedge clk_i);
      rdata = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   end
   endtask
   task sleep(input [7:0] ctrl);
   begin
      apb(1'b1, 12'h000, {24'h0, ctrl});
      @(posedge clk_i);
      halt_req <= 1'b1;
      @(posedge clk_i);
      halt_req <= 1'b0;
      cs = 1'b0;
      repeat (4)
      begin
         @(negedge clk_i);
         cs = cs | conv_o;
      end
      @(posedge clk_i);
   end
   endtask
   task wait_wake;
   begin
      n = 0;
      while (resume_irq_o !== 1'b1 && resume_reset_o !== 1'b1 && n < 300)
      begin
         @(negedge clk_i);
         n = n + 1;
      end
      rr = resume_reset_o;
      @(posedge clk_i);
   end
   endtask
   task t_regs;
   begin
      apb(1'b0, 12'h000, 32'h0);
      check("ctrl reset", 32'h0, rdata);
      apb(1'b1, 12'h004, 32'hff);
      apb(1'b0, 12'h004, 32'h0);
      check("gate read", 32'hf, rdata);
      check("gate out", 32'hf, {28'h0, gate_o});
      check("io block", 32'hf, {28'h0, block_o});
      apb(1'b1, 12'h004, 32'h0);
      check("io free", 32'h0, {28'h0, block_o});
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped", 32'h1, {31'h0, rerr});
      $display("test regs done");
   end
   endtask
   task t_modes;
   begin
      for (m = 0; m < 3; m = m + 1)
      begin
         conv_en <= (m != 0);
         sleep({3'b001, m[1:0], 3'b000});
         check("clock set", m == 0 ? 6'h0f : m == 1 ? 6'h05 : 6'h00, en_v);
         check("conv start", m == 1, cs);
         irq_v <= 7'h10 >> m;
         wait_wake;
         irq_v <= 7'h00;
         check("wake time", 1, n >= OSC + 4 && n <= OSC + 10);
         check("wake kind", 0, rr);
      end
      $display("test modes done");
   end
   endtask
   task t_filter;
   begin
      sleep(8'h10);
      check("no enable", 1, c_en);
      sleep(8'h38);
      check("reserved", 1, c_en);
      apb(1'b1, 12'h00c, 32'h0);
      sleep(8'h30);
      irq_v <= 7'h3a;
      ext_req <= 1'b1;
      repeat (30) @(posedge clk_i);
      check("pdown held", 1, core_hold_o);
      irq_v <= 7'h00;
      ext_req <= 1'b0;
      sleep_reset_i <= 1'b1;
      wait_wake;
      sleep_reset_i <= 1'b0;
      check("reset wake", 1, rr);
      apb(1'b1, 12'h00c, 32'h1);
      sleep(8'h28);
      irq_v <= 7'h30;
      repeat (30) @(posedge clk_i);
      check("noise held", 1, core_hold_o);
      irq_v <= 7'h00;
      ext_req <= 1'b1;
      wait_wake;
      ext_req <= 1'b0;
      check("level wake", 1, n < 300 && !rr);
      $display("test filter done");
   end
   endtask
   task t_bod;
   begin
      apb(1'b1, 12'h000, 32'h84);
      sleep(8'hb0);
      check("bod off", 0, bod_en);
      irq_v <= 7'h40;
      wait_wake;
      irq_v <= 7'h00;
      check("bod wake", 1, n >= RST + 4 && n <= RST + 10);
      check("bod on", 1, bod_en);
      apb(1'b0, 12'h000, 32'h0);
      check("bod clear", 0, rdata[7]);
      apb(1'b1, 12'h000, 32'h84);
      repeat (6) @(posedge clk_i);
      sleep(8'hb0);
      check("bod kept", 1, bod_en);
      irq_v <= 7'h40;
      wait_wake;
      irq_v <= 7'h00;
      check("kept wake", 1, n >= OSC + 4 && n <= OSC + 10);
      $display("test bod done");
   end
   endtask
   task report_and_stop;
   begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs;
      t_modes;
      t_filter;
      t_bod;
      report_and_stop;
   end
   initial
   begin
      #(25 * 20000);
      failures = failures + 1;
      report_and_stop;
   end
endmodule
